// *** logic/mbf_pkg.sv ***
// Notes on behaviour
// - Filter mode 100: triple-check line messages, report them, enable echo reception.
// - Filter mode 001: forward every received line message each 6 ms, unfiltered.
// - Filter mode 010: report a line message only when it differs from the last.
// - Filter mode 011: report a changed command after three identical messages.
// - A changed status value is repeated in three superframes by its sender.
// - All overhead bits become one when leaving power-down.
// - Each status bit is validated alone; algorithm chosen by field bits 3 and 4.
// - Field bit 5 picks triple match or the reporting algorithm for state machine.
// - Spare bits use the status algorithm or on change; never checksum covered.
// - Checksum covered bits are reported one superframe later, after the check.
// - Once after reset the mode strap presets the low three filter bits.
// - Once after reset the checksum strap presets the upper filter bits.
// - Config stays writable; it takes effect on each entry to deactivated.
// - With triple match, status changes reach the state machine once approved.
// - Same filter plus checksum: state machine informed at next superframe end.
// - Cleared source mask bit sends the commanded status bit, else state machine's.
// - Source mask bit 6 selects the busy bit source; busy-select command writes it.
// - Report mask gates status reports; its bit 6 picks received busy or one.
// - Commanded status goes in the next superframe; reports carry validated values.
// - Spare bit commands accepted anytime; reports carry last verified spare bits.
// - Monitor messages are only issued while the receiver is synchronized.
package mbf_pkg;

  localparam int unsigned M4_W      = 8;
  localparam int unsigned SP_W      = 3;
  localparam int unsigned EOC_W     = 12;
  localparam int unsigned TRIPLE_N  = 3;

  // Register indices on the register-access message port
  localparam logic [1:0] REG_CFG    = 2'h0;
  localparam logic [1:0] REG_TXMASK = 2'h1;
  localparam logic [1:0] REG_RXMASK = 2'h2;
  localparam logic [1:0] REG_ACTCFG = 2'h3;

  // Filter config field positions
  localparam int unsigned CFG_EOC_LSB = 0;
  localparam int unsigned CFG_M4_LSB  = 3;
  localparam int unsigned CFG_FSM_BIT = 5;
  localparam int unsigned CFG_M56_BIT = 6;
  localparam int unsigned BUSY_BIT    = 6;

  // Strap preset values
  localparam logic [2:0] CFG_LO_AUTO  = 3'h4;
  localparam logic [2:0] CFG_LO_TRANS = 3'h1;
  localparam logic [4:0] CFG_HI_CHK   = 5'h06;
  localparam logic [4:0] CFG_HI_NOCHK = 5'h00;

  localparam logic [7:0] TXMASK_RST = 8'hFF;
  localparam logic [7:0] RXMASK_RST = 8'hFF;
  localparam logic [2:0] LAST_FRAME = 3'h7;
  localparam logic [1:0] EOC_LAST   = 2'h3;

  typedef enum logic [2:0] {
    EOC_TRANSP = 3'b001,
    EOC_ONCHG  = 3'b010,
    EOC_TRIPLE = 3'b011,
    EOC_AUTO   = 3'b100
  } mbf_eoc_mode_t;

  typedef enum logic [1:0] {
    ALG_CHANGE = 2'b00,
    ALG_TRIPLE = 2'b01,
    ALG_CHECK  = 2'b10,
    ALG_BOTH   = 2'b11
  } mbf_alg_t;

endpackage

// *** logic/mbf_eoc_if.sv ***
`timescale 1ns/1ps
interface mbf_eoc_if;
  logic                       word_valid;
  logic [mbf_pkg::EOC_W-1:0]  word;
  mbf_pkg::mbf_eoc_mode_t     mode;
  logic                       tx_valid;
  logic [mbf_pkg::EOC_W-1:0]  tx_word;
  logic                       out_valid;
  logic [mbf_pkg::EOC_W-1:0]  out_word;

  modport top  (output word_valid, word, mode, tx_valid, tx_word,
                input  out_valid, out_word);
  modport filt (input  word_valid, word, mode, tx_valid, tx_word,
                output out_valid, out_word);
endinterface

// *** logic/mbf_triple_match.sv ***
`timescale 1ns/1ps
module mbf_triple_match #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic [W-1:0] smp_en,
  input  wire logic [W-1:0] smp,
  output logic      [W-1:0] acc
);

  logic [W-1:0] cand_ff;
  logic [W-1:0] acc_ff;
  logic [1:0]   cnt_ff [W];

  // Per-bit candidate and run length
  always_ff @(posedge clk) begin
    for (int i = 0; i < W; i++) begin
      if (!nrst || load) begin
        cand_ff[i] <= 1'b1;
        cnt_ff[i]  <= 2'h0;
      end else if (smp_en[i]) begin
        cand_ff[i] <= smp[i];
        if (smp[i] != cand_ff[i]) begin
          cnt_ff[i] <= 2'h1;
        end else if (cnt_ff[i] < 2'(mbf_pkg::TRIPLE_N - 1)) begin
          cnt_ff[i] <= cnt_ff[i] + 2'h1;
        end
      end
    end
  end

  // Accept on the third identical sample; hold otherwise
  always_ff @(posedge clk) begin
    for (int i = 0; i < W; i++) begin
      if (!nrst) begin
        acc_ff[i] <= 1'b1;
      end else if (load) begin
        acc_ff[i] <= load_val[i];
      end else if (smp_en[i] && smp[i] == cand_ff[i]
                   && cnt_ff[i] == 2'(mbf_pkg::TRIPLE_N - 1)) begin
        acc_ff[i] <= smp[i];
      end
    end
  end

  assign acc = acc_ff;

endmodule // mbf_triple_match

// *** logic/mbf_eoc_filter.sv ***
`timescale 1ns/1ps
module mbf_eoc_filter (
  input  wire logic clk,
  input  wire logic nrst,
  mbf_eoc_if.filt   eoc
);

  localparam int unsigned EW = mbf_pkg::EOC_W;

  logic [EW-1:0] prev_ff;
  logic [EW-1:0] cand_ff;
  logic [EW-1:0] rep_ff;
  logic [EW-1:0] ret_word_ff;
  logic [1:0]    cnt_ff;
  logic          ret_en_ff;
  logic          out_valid_ff;
  logic [EW-1:0] out_word_ff;
  logic          same;
  logic          hit;
  logic          fire;

  assign same = (eoc.word == cand_ff);
  assign hit  = same && cnt_ff == 2'(mbf_pkg::TRIPLE_N - 1);

  always_comb begin
    unique case (eoc.mode)
      mbf_pkg::EOC_TRANSP: fire = 1'b1;
      mbf_pkg::EOC_ONCHG:  fire = (eoc.word != prev_ff);
      mbf_pkg::EOC_TRIPLE: fire = hit && (eoc.word != rep_ff);
      mbf_pkg::EOC_AUTO:   fire = hit && (eoc.word != rep_ff
                                  || (ret_en_ff && eoc.word == ret_word_ff));
      default:             fire = 1'b0;
    endcase
  end

  // Echo reception armed once a command has gone downstream
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ret_en_ff   <= 1'b0;
      ret_word_ff <= '1;
    end else if (eoc.tx_valid) begin
      ret_en_ff   <= 1'b1;
      ret_word_ff <= eoc.tx_word;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prev_ff <= '1;
      cand_ff <= '1;
      cnt_ff  <= 2'h0;
      rep_ff  <= '1;
    end else if (eoc.word_valid) begin
      prev_ff <= eoc.word;
      cand_ff <= eoc.word;
      if (!same) begin
        cnt_ff <= 2'h1;
      end else if (!hit && cnt_ff < 2'(mbf_pkg::TRIPLE_N - 1)) begin
        cnt_ff <= cnt_ff + 2'h1;
      end
      if (fire) begin
        rep_ff <= eoc.word;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_valid_ff <= 1'b0;
      out_word_ff  <= '1;
    end else begin
      out_valid_ff <= eoc.word_valid && fire;
      if (eoc.word_valid && fire) begin
        out_word_ff <= eoc.word;
      end
    end
  end

  assign eoc.out_valid = out_valid_ff;
  assign eoc.out_word  = out_word_ff;

endmodule // mbf_eoc_filter

// *** logic/mbf_maint_filter.sv ***
`timescale 1ns/1ps
module mbf_maint_filter #(
  parameter logic [7:0] TXMASK_INIT = mbf_pkg::TXMASK_RST,
  parameter logic [7:0] RXMASK_INIT = mbf_pkg::RXMASK_RST
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        auto_mode_strap,
  input  wire logic        check_filter_strap,
  input  wire logic        rx_sync,
  input  wire logic        deact_entry,
  input  wire logic        pdown_exit,
  input  wire logic        rx_frame,
  input  wire logic [2:0]  rx_frame_num,
  input  wire logic [2:0]  rx_eoc_bits,
  input  wire logic        rx_m4_bit,
  input  wire logic        rx_m5_bit,
  input  wire logic        rx_m6_bit,
  input  wire logic        rx_check_ok,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [1:0]  reg_idx,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        busy_sel_valid,
  input  wire logic        busy_sel_fsm,
  input  wire logic        ovh_cmd_valid,
  input  wire logic [7:0]  ovh_cmd_m4,
  input  wire logic [2:0]  ovh_cmd_spare,
  input  wire logic        ops_cmd_valid,
  input  wire logic [11:0] ops_cmd_word,
  input  wire logic [7:0]  fsm_tx_m4,
  output logic             ops_msg_valid,
  output logic      [11:0] ops_msg_data,
  output logic             ovh_msg_valid,
  output logic      [7:0]  ovh_msg_m4,
  output logic      [2:0]  ovh_msg_spare,
  output logic      [7:0]  fsm_rx_m4,
  output logic             fsm_st_busy,
  output logic      [7:0]  tx_m4,
  output logic      [2:0]  tx_spare
);

  localparam int unsigned MW = mbf_pkg::M4_W;
  localparam int unsigned SW = mbf_pkg::SP_W;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic mbf_pkg::mbf_alg_t m4_alg(input logic [7:0] cfg);
    return mbf_pkg::mbf_alg_t'(cfg[mbf_pkg::CFG_M4_LSB +: 2]);
  endfunction

  function automatic logic [7:0] strap_cfg(input logic auto_s, input logic chk_s);
    return {chk_s ? mbf_pkg::CFG_HI_CHK : mbf_pkg::CFG_HI_NOCHK,
            auto_s ? mbf_pkg::CFG_LO_AUTO : mbf_pkg::CFG_LO_TRANS};
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] cfg_ff;
  logic [7:0] cfg_act_ff;
  logic [7:0] txmask_ff;
  logic [7:0] rxmask_ff;
  logic       strap_done_ff;
  logic [7:0] rdata_ff;

  // Straps are caught on the first clock after reset release
  always_ff @(posedge clk) begin
    if (!nrst) begin
      strap_done_ff <= 1'b0;
    end else begin
      strap_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_ff <= 8'h00;
    end else if (!strap_done_ff) begin
      cfg_ff <= strap_cfg(auto_mode_strap, check_filter_strap);
    end else if (reg_wr && reg_idx == mbf_pkg::REG_CFG) begin
      cfg_ff <= reg_wdata;
    end
  end

  // Working copy only follows the register on entry to deactivated
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_act_ff <= 8'h00;
    end else if (!strap_done_ff) begin
      cfg_act_ff <= strap_cfg(auto_mode_strap, check_filter_strap);
    end else if (deact_entry) begin
      cfg_act_ff <= cfg_ff;
    end
  end

  // Busy-select command shares bit 6 with the register; the later
  // write wins. Alternating them during loop test is the caller's fault.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      txmask_ff <= TXMASK_INIT;
    end else if (busy_sel_valid) begin
      txmask_ff[mbf_pkg::BUSY_BIT] <= busy_sel_fsm;
    end else if (reg_wr && reg_idx == mbf_pkg::REG_TXMASK) begin
      txmask_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxmask_ff <= RXMASK_INIT;
    end else if (reg_wr && reg_idx == mbf_pkg::REG_RXMASK) begin
      rxmask_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_idx)
        mbf_pkg::REG_CFG:    rdata_ff <= cfg_ff;
        mbf_pkg::REG_TXMASK: rdata_ff <= txmask_ff;
        mbf_pkg::REG_RXMASK: rdata_ff <= rxmask_ff;
        mbf_pkg::REG_ACTCFG: rdata_ff <= cfg_act_ff;
      endcase
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Frame assembly
  // ----------------------------------------------------------------
  logic [MW-1:0] m4_sh_ff;
  logic [SW-1:0] sp_sh_ff;
  logic [8:0]    eoc_sh_ff;
  logic          sf_end;
  logic [MW-1:0] m4_sf;
  logic [SW-1:0] sp_sf;

  assign sf_end = rx_frame && rx_frame_num == mbf_pkg::LAST_FRAME;

  always_comb begin
    m4_sf = m4_sh_ff;
    m4_sf[rx_frame_num] = rx_m4_bit;
  end

  assign sp_sf = sp_sh_ff;

  // Spare bits: frame 0 M5, frame 1 M5, frame 0 M6; error bit skipped
  always_ff @(posedge clk) begin
    if (!nrst) begin
      m4_sh_ff  <= '1;
      sp_sh_ff  <= '1;
      eoc_sh_ff <= '1;
    end else if (rx_frame) begin
      m4_sh_ff  <= m4_sf;
      eoc_sh_ff <= {eoc_sh_ff[5:0], rx_eoc_bits};
      if (rx_frame_num == 3'h0) begin
        sp_sh_ff[0] <= rx_m5_bit;
        sp_sh_ff[2] <= rx_m6_bit;
      end
      if (rx_frame_num == 3'h1) begin
        sp_sh_ff[1] <= rx_m5_bit;
      end
    end
  end

  // ----------------------------------------------------------------
  // Line message channel
  // ----------------------------------------------------------------
  mbf_eoc_if eoc_bus ();

  assign eoc_bus.word_valid = rx_frame && rx_frame_num[1:0] == mbf_pkg::EOC_LAST;
  assign eoc_bus.word       = {eoc_sh_ff, rx_eoc_bits};
  assign eoc_bus.mode       = mbf_pkg::mbf_eoc_mode_t'(cfg_act_ff[mbf_pkg::CFG_EOC_LSB +: 3]);
  assign eoc_bus.tx_valid   = ops_cmd_valid;
  assign eoc_bus.tx_word    = ops_cmd_word;

  mbf_eoc_filter u_eoc (
    .clk  (clk),
    .nrst (nrst),
    .eoc  (eoc_bus.filt)
  );

  assign ops_msg_valid = eoc_bus.out_valid && rx_sync;
  assign ops_msg_data  = eoc_bus.out_word;

  // ----------------------------------------------------------------
  // Checksum cover: hold a superframe until its check arrives
  // ----------------------------------------------------------------
  logic [MW-1:0] pend_m4_ff;
  logic          pend_vld_ff;
  logic [MW-1:0] cp_m4_ff;
  logic          check_pass;
  logic          check_pass_d_ff;
  logic          sf_end_d_ff;
  logic [MW-1:0] raw_m4_ff;
  logic [SW-1:0] raw_sp_ff;

  assign check_pass = sf_end && pend_vld_ff && rx_check_ok;

  always_ff @(posedge clk) begin
    if (!nrst || pdown_exit) begin
      pend_m4_ff  <= '1;
      pend_vld_ff <= 1'b0;
      cp_m4_ff    <= '1;
    end else if (sf_end) begin
      pend_m4_ff  <= m4_sf;
      pend_vld_ff <= 1'b1;
      if (check_pass) begin
        cp_m4_ff <= pend_m4_ff;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sf_end_d_ff     <= 1'b0;
      check_pass_d_ff <= 1'b0;
      raw_m4_ff       <= '1;
      raw_sp_ff       <= '1;
    end else begin
      sf_end_d_ff     <= sf_end;
      check_pass_d_ff <= check_pass;
      if (sf_end) begin
        raw_m4_ff <= m4_sf;
        raw_sp_ff <= sp_sf;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-bit triple match filters
  // ----------------------------------------------------------------
  logic [MW-1:0] tll_raw;
  logic [MW-1:0] tll_chk;
  logic [SW-1:0] tll_sp;
  logic [MW-1:0] bit_en;

  assign bit_en = rx_frame ? MW'(1) << rx_frame_num : '0;

  mbf_triple_match #(.W(MW)) u_tll_raw (
    .clk      (clk),
    .nrst     (nrst),
    .load     (pdown_exit),
    .load_val ({MW{1'b1}}),
    .smp_en   (bit_en),
    .smp      ({MW{rx_m4_bit}}),
    .acc      (tll_raw)
  );

  mbf_triple_match #(.W(MW)) u_tll_chk (
    .clk      (clk),
    .nrst     (nrst),
    .load     (pdown_exit),
    .load_val ({MW{1'b1}}),
    .smp_en   ({MW{check_pass}}),
    .smp      (pend_m4_ff),
    .acc      (tll_chk)
  );

  mbf_triple_match #(.W(SW)) u_tll_sp (
    .clk      (clk),
    .nrst     (nrst),
    .load     (pdown_exit),
    .load_val ({SW{1'b1}}),
    .smp_en   ({SW{sf_end}}),
    .smp      (sp_sf),
    .acc      (tll_sp)
  );

  // ----------------------------------------------------------------
  // Validated values and reporting
  // ----------------------------------------------------------------
  logic [MW-1:0] val_m4_ff;
  logic [SW-1:0] val_sp_ff;
  logic [MW-1:0] nxt_val_m4;
  logic [SW-1:0] nxt_val_sp;
  logic          nxt_report;
  logic          ovh_valid_ff;
  logic [MW-1:0] ovh_m4_ff;
  logic [SW-1:0] ovh_sp_ff;

  always_comb begin
    unique case (m4_alg(cfg_act_ff))
      mbf_pkg::ALG_CHANGE: nxt_val_m4 = raw_m4_ff;
      mbf_pkg::ALG_TRIPLE: nxt_val_m4 = tll_raw;
      mbf_pkg::ALG_CHECK:  nxt_val_m4 = check_pass_d_ff ? cp_m4_ff : val_m4_ff;
      mbf_pkg::ALG_BOTH:   nxt_val_m4 = tll_chk;
    endcase
  end

  // Spare bits never see the checksum, so check modes drop to the rest
  always_comb begin
    if (cfg_act_ff[mbf_pkg::CFG_M56_BIT]) begin
      nxt_val_sp = raw_sp_ff;
    end else begin
      unique case (m4_alg(cfg_act_ff))
        mbf_pkg::ALG_CHANGE: nxt_val_sp = raw_sp_ff;
        mbf_pkg::ALG_TRIPLE: nxt_val_sp = tll_sp;
        mbf_pkg::ALG_CHECK:  nxt_val_sp = raw_sp_ff;
        mbf_pkg::ALG_BOTH:   nxt_val_sp = tll_sp;
      endcase
    end
  end

  assign nxt_report = (|((nxt_val_m4 ^ val_m4_ff) & rxmask_ff))
                      || (nxt_val_sp != val_sp_ff);

  // Values settle one cycle after superframe end so the last bit counts
  always_ff @(posedge clk) begin
    if (!nrst || pdown_exit) begin
      val_m4_ff <= '1;
      val_sp_ff <= '1;
    end else if (sf_end_d_ff) begin
      val_m4_ff <= nxt_val_m4;
      val_sp_ff <= nxt_val_sp;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ovh_valid_ff <= 1'b0;
      ovh_m4_ff    <= '1;
      ovh_sp_ff    <= '1;
    end else begin
      ovh_valid_ff <= sf_end_d_ff && nxt_report && rx_sync;
      if (sf_end_d_ff && nxt_report) begin
        ovh_m4_ff <= nxt_val_m4;
        ovh_sp_ff <= nxt_val_sp;
      end
    end
  end

  assign ovh_msg_valid = ovh_valid_ff;
  assign ovh_msg_m4    = ovh_m4_ff;
  assign ovh_msg_spare = ovh_sp_ff;

  // Triple path reaches the state machine per bit, mid-superframe
  assign fsm_rx_m4 = cfg_act_ff[mbf_pkg::CFG_FSM_BIT] ? val_m4_ff
                                                      : tll_raw;
  assign fsm_st_busy = rxmask_ff[mbf_pkg::BUSY_BIT] ? fsm_rx_m4[mbf_pkg::BUSY_BIT]
                                                    : 1'b1;

  // ----------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------
  logic [MW-1:0] cmd_m4_ff;
  logic [SW-1:0] cmd_sp_ff;
  logic [MW-1:0] tx_m4_ff;
  logic [SW-1:0] tx_sp_ff;

  always_ff @(posedge clk) begin
    if (!nrst || pdown_exit) begin
      cmd_m4_ff <= '1;
      cmd_sp_ff <= '1;
    end else if (ovh_cmd_valid) begin
      cmd_m4_ff <= ovh_cmd_m4;
      cmd_sp_ff <= ovh_cmd_spare;
    end
  end

  // Latched at superframe end: a command lands in the next superframe
  always_ff @(posedge clk) begin
    if (!nrst || pdown_exit) begin
      tx_m4_ff <= '1;
      tx_sp_ff <= '1;
    end else if (sf_end) begin
      tx_m4_ff <= (txmask_ff & fsm_tx_m4) | (~txmask_ff & cmd_m4_ff);
      tx_sp_ff <= cmd_sp_ff;
    end
  end

  // The sender holds a new value for three superframes itself
  assign tx_m4    = tx_m4_ff;
  assign tx_spare = tx_sp_ff;

endmodule // mbf_maint_filter

// *** tb/mbf_maint_filter_properties.sv ***
`timescale 1ns/1ps
// ------------------------------
// Port checker for maint filter
// ------------------------------
module mbf_maint_filter_properties (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       rx_sync,
  input wire logic       rx_frame,
  input wire logic [2:0] rx_frame_num,
  input wire logic       pdown_exit,
  input wire logic       deact_entry,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       ops_msg_valid,
  input wire logic       ovh_msg_valid,
  input wire logic [7:0] fsm_rx_m4,
  input wire logic       fsm_st_busy,
  input wire logic [7:0] tx_m4,
  input wire logic [2:0] tx_spare
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ops_sync_gate: assert property (ops_msg_valid |-> rx_sync)
    else $error("line report while unsynchronized");
  // Valid is registered, so sync may have dropped one cycle earlier
  a_ovh_sync_gate: assert property (ovh_msg_valid |-> rx_sync || $past(rx_sync))
    else $error("overhead report while unsynchronized");
  a_ops_word_end: assert property (ops_msg_valid |->
    $past(rx_frame) && ($past(rx_frame_num) inside {3'h3, 3'h7}))
    else $error("line report not after word end");
  a_ovh_sf_end: assert property (ovh_msg_valid |->
    $past(rx_frame, 2) && $past(rx_frame_num, 2) == 3'h7)
    else $error("overhead report not after superframe end");
  a_ops_one_shot: assert property (ops_msg_valid |=> !ops_msg_valid)
    else $error("line report longer than one cycle");
  a_pdown_ones: assert property (pdown_exit |=>
    tx_m4 == 8'hFF && tx_spare == 3'h7 && fsm_rx_m4 == 8'hFF)
    else $error("overhead bits not ones after power-down exit");
  a_busy_source: assert property (!fsm_st_busy |-> !fsm_rx_m4[6])
    else $error("busy low without received busy low");
  a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_fsm_cause: assert property ($changed(fsm_rx_m4) |-> $past(rx_frame) ||
    $past(rx_frame, 2) || $past(pdown_exit) || $past(deact_entry))
    else $error("state machine bits moved without cause");
  a_tx_latch: assert property ($changed(tx_m4) |->
    ($past(rx_frame) && $past(rx_frame_num) == 3'h7) || $past(pdown_exit))
    else $error("transmit bits moved off superframe end");
endmodule // mbf_maint_filter_properties

bind mbf_maint_filter mbf_maint_filter_properties mbf_maint_filter_properties_i (.*);

// *** tb/mbf_ctrl_model.sv ***
`timescale 1ns/1ps
// ---------------------------
// System controller stand-in
// ---------------------------
module mbf_ctrl_model (
  input  wire logic        clk,
  input  wire logic        loop_test,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [1:0]  reg_idx,
  output logic      [7:0]  reg_wdata,
  input  wire logic [7:0]  reg_rdata,
  output logic             busy_sel_valid,
  output logic             busy_sel_fsm,
  output logic             ovh_cmd_valid,
  output logic      [7:0]  ovh_cmd_m4,
  output logic      [2:0]  ovh_cmd_spare,
  input  wire logic        ops_msg_valid,
  input  wire logic [11:0] ops_msg_data
);
  int          ops_cnt = 0;
  logic [11:0] ops_last;
  initial {reg_wr, reg_rd, busy_sel_valid, busy_sel_fsm, ovh_cmd_valid} = '0;
  initial {reg_idx, reg_wdata, ovh_cmd_m4, ovh_cmd_spare} = '0;
  always @(posedge clk) begin
    if (ops_msg_valid === 1'b1) begin
      ops_cnt++;
      ops_last = ops_msg_data;
    end
  end
  // Mask rewrites in loop test can make the busy bits oscillate
  task automatic wr(input logic [1:0] i, input logic [7:0] v);
    if (loop_test && i == 2'h1) return;
    reg_idx = i;
    reg_wdata = v;
    reg_wr = 1;
    @(posedge clk) #1;
    reg_wr = 0;
    @(posedge clk) #1;
  endtask
  task automatic rd(input logic [1:0] i, output logic [7:0] v);
    reg_idx = i;
    reg_rd = 1;
    @(posedge clk) #1;
    reg_rd = 0;
    v = reg_rdata;
    @(posedge clk) #1;
  endtask
  task automatic busy(input logic f);
    if (loop_test) return;
    busy_sel_fsm = f;
    busy_sel_valid = 1;
    @(posedge clk) #1;
    busy_sel_valid = 0;
    @(posedge clk) #1;
  endtask
  task automatic ovh(input logic [7:0] m, input logic [2:0] s);
    ovh_cmd_m4 = m;
    ovh_cmd_spare = s;
    ovh_cmd_valid = 1;
    @(posedge clk) #1;
    ovh_cmd_valid = 0;
    @(posedge clk) #1;
  endtask
endmodule // mbf_ctrl_model

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
// ---------
// Bench top
// ---------
module tb_top;
  logic        clk = 1'b0, nrst, auto_mode_strap, check_filter_strap, rx_sync, loop_test;
  logic        deact_entry, pdown_exit, rx_frame, rx_m4_bit, rx_m5_bit, rx_m6_bit;
  logic        rx_check_ok, reg_wr, reg_rd, busy_sel_valid, busy_sel_fsm;
  logic        ovh_cmd_valid, ops_cmd_valid, ops_msg_valid, ovh_msg_valid, fsm_st_busy;
  logic [1:0]  reg_idx;
  logic [2:0]  rx_frame_num, rx_eoc_bits, ovh_cmd_spare, ovh_msg_spare, tx_spare;
  logic [7:0]  reg_wdata, reg_rdata, ovh_cmd_m4, fsm_tx_m4, ovh_msg_m4, fsm_rx_m4, tx_m4, p, c;
  logic [11:0] ops_cmd_word, ops_msg_data, w0, w1, w2;
  logic [31:0] seed = 32'h0000CF49;
  int          err_count = 0, check_count = 0, ovh_cnt = 0, n0, v0;

  mbf_maint_filter mbf_maint_filter_i (.*);
  mbf_ctrl_model   mbf_ctrl_model_i (.*);

  initial forever #4 clk = ~clk;
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    final_report();
  end
  always @(posedge clk) if (ovh_msg_valid === 1'b1) ovh_cnt++;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rdc(input logic [1:0] i, input logic [7:0] e, input string nm);
    logic [7:0] v;
    mbf_ctrl_model_i.rd(i, v);
    chk(nm, {4'h0, v}, {4'h0, e});
  endtask
  task automatic rst(input logic a, input logic k);
    nrst = 0;
    auto_mode_strap = a;
    check_filter_strap = k;
    cyc(12);
    nrst = 1;
    cyc(2);
  endtask
  task automatic mode(input logic [7:0] m);
    mbf_ctrl_model_i.wr(2'h0, m);
    deact_entry = 1;
    cyc();
    deact_entry = 0;
  endtask
  // Frames two cycles apart, line word msb first
  task automatic sf(input logic [11:0] a, input logic [11:0] b, input logic [7:0] m);
    logic [23:0] w;
    w = {a, b};
    for (int i = 0; i < 8; i++) begin
      rx_frame = 1;
      rx_frame_num = i[2:0];
      rx_eoc_bits = w[23-3*i -: 3];
      rx_m4_bit = m[i];
      cyc();
      rx_frame = 0;
      rx_eoc_bits = ~rx_eoc_bits;
      cyc();
    end
    cyc(2);
  endtask
  task automatic ops_exp(input int n, input logic [11:0] last);
    chk("ops count", 12'(mbf_ctrl_model_i.ops_cnt - n0), 12'(n));
    chk("ops data", mbf_ctrl_model_i.ops_last, last);
    n0 = mbf_ctrl_model_i.ops_cnt;
  endtask

  initial begin
    {rx_sync, deact_entry, pdown_exit, rx_frame, loop_test, fsm_tx_m4} = '0;
    {rx_frame_num, rx_eoc_bits, rx_m4_bit, ops_cmd_valid, ops_cmd_word} = '0;
    {rx_m5_bit, rx_m6_bit, rx_check_ok} = 3'h7;
    rst(1'b0, 1'b0);
    rdc(2'h0, 8'h01, "strap low");
    rst(1'b1, 1'b1);
    rdc(2'h0, 8'h34, "strap high");
    rdc(2'h3, 8'h34, "working cfg");
    $display("end strap test");
    seed = xs(seed);
    w0 = seed[11:0];
    w1 = ~w0;
    w2 = w0 ^ 12'h001;
    rx_sync = 1;
    mode(8'h01);
    n0 = mbf_ctrl_model_i.ops_cnt;
    sf(w0, w1, 8'hFF);
    sf(w0, w1, 8'hFF);
    ops_exp(4, w1);
    rx_sync = 0;
    sf(w0, w1, 8'hFF);
    ops_exp(0, w1);
    rx_sync = 1;
    mode(8'h02);
    sf(w0, w0, 8'hFF);
    sf(w1, w1, 8'hFF);
    ops_exp(2, w1);
    mode(8'h03);
    sf(w2, w2, 8'hFF);
    sf(w2, w0, 8'hFF);
    ops_exp(1, w2);
    mode(8'h04);
    {ops_cmd_valid, ops_cmd_word} = {1'b1, w2};
    cyc();
    ops_cmd_valid = 0;
    sf(w2, w2, 8'hFF);
    sf(w2, w0, 8'hFF);
    sf(w1, w1, 8'hFF);
    sf(w1, w0, 8'hFF);
    ops_exp(2, w1);
    $display("end line filter test");
    p = {seed[31], 1'b0, seed[29:25], 1'b0};
    v0 = ovh_cnt;
    sf(w1, w1, p);
    chk("ovh count", 12'(ovh_cnt - v0), 12'h001);
    chk("ovh m4", {4'h0, ovh_msg_m4}, {4'h0, p});
    chk("fsm early", {4'h0, fsm_rx_m4}, 12'h0FF);
    sf(w1, w1, p);
    sf(w1, w1, p);
    chk("fsm triple", {4'h0, fsm_rx_m4}, {4'h0, p});
    chk("ovh once", 12'(ovh_cnt - v0), 12'h001);
    chk("busy rx", {11'h0, fsm_st_busy}, 12'h000);
    mbf_ctrl_model_i.wr(2'h2, 8'hBF);
    chk("busy one", {11'h0, fsm_st_busy}, 12'h001);
    sf(w1, w1, p ^ 8'h40);
    chk("ovh masked", 12'(ovh_cnt - v0), 12'h001);
    $display("end overhead rx test");
    fsm_tx_m4 = seed[15:8];
    c = seed[7:0];
    mbf_ctrl_model_i.wr(2'h1, 8'hF0);
    mbf_ctrl_model_i.ovh(c, 3'h2);
    mbf_ctrl_model_i.busy(1'b0);
    rdc(2'h1, 8'hB0, "tx mask");
    sf(w1, w1, p);
    chk("tx m4", {4'h0, tx_m4}, {4'h0, (8'hB0 & fsm_tx_m4) | (8'h4F & c)});
    chk("tx spare", {9'h0, tx_spare}, 12'h002);
    mbf_ctrl_model_i.wr(2'h3, 8'h5A);
    rdc(2'h3, 8'h04, "ro cfg");
    $display("end transmit test");
    pdown_exit = 1;
    cyc();
    pdown_exit = 0;
    cyc();
    chk("pdown tx", {4'h0, tx_m4}, 12'h0FF);
    chk("pdown rx", {4'h0, fsm_rx_m4}, 12'h0FF);
    $display("end power-down test");
    rx_m5_bit = 0;
    mode(8'h14);
    v0 = ovh_cnt;
    sf(w1, w1, p);
    chk("ovh spare", {9'h0, ovh_msg_spare}, 12'h004);
    chk("ovh held", {4'h0, ovh_msg_m4}, 12'h0FF);
    sf(w1, w1, 8'hFF);
    chk("ovh checked", {4'h0, ovh_msg_m4}, {4'h0, p});
    chk("ovh two", 12'(ovh_cnt - v0), 12'h002);
    $display("end checksum test");
    final_report();
  end
endmodule // tb_top
